// File: design/jump_incr_core.sv
// Purpose: Execution core for the long jump and byte increment, AXI4-Lite control
// Assumes: Program and data memories answer on aclk; four clocks per instruction cycle, two cycles for a jump
// Notes: Other opcodes execute as no operation
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module jump_incr_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [20:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  output core_pkg::dmem_req_t dmem,
  input wire logic [7:0] dmem_rdata
);
  import core_pkg::*;

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic is_jump(input logic [15:0] w);
    is_jump = (w[15:8] == JUMP_W1_OP);
  endfunction

  function automatic logic is_inc_file(input logic [15:0] w);
    is_inc_file = (w[15:10] == INC_FILE_OP);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic aw_got_ff, w_got_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] ctrl_ff;
  logic [3:0] bank_ff;
  logic [11:0] idx_ff;
  logic [7:0] wreg_ff;
  logic [4:0] status_ff;
  logic [20:0] pc_ff;
  logic [15:0] ir_ff;
  logic [1:0] q_ff;
  exec_st_t st_ff, nxt_st;
  logic [7:0] klo_ff;
  logic [7:0] opnd_ff;
  alu_out_t res_ff;
  dmem_req_t dmem_ff;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  logic aw_hs, w_hs, aw_have, w_have, do_wr;
  logic nxt_bvalid, nxt_awready, nxt_wready;
  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  logic wa_hit;
  assign aw_hs = awvalid & awready_ff;
  assign w_hs = wvalid & wready_ff;
  assign aw_have = aw_got_ff | aw_hs;
  assign w_have = w_got_ff | w_hs;
  assign do_wr = aw_have & w_have;
  assign nxt_bvalid = do_wr | (bvalid_ff & ~bready);
  assign nxt_awready = ~(aw_have & ~do_wr) & ~nxt_bvalid;
  assign nxt_wready = ~(w_have & ~do_wr) & ~nxt_bvalid;
  assign wa = aw_hs ? awaddr : awaddr_ff;
  assign wd = w_hs ? wdata : wdata_ff;
  assign ws = w_hs ? wstrb : wstrb_ff;
  assign wa_hit = (wa == OFS_CTRL) | (wa == OFS_PC) | (wa == OFS_WREG) | (wa == OFS_BANK)
                | (wa == OFS_STATUS) | (wa == OFS_IDX) | (wa == OFS_IR);

  // Per-register write strobes and merged values
  logic wr_ctrl, wr_pc, wr_wreg, wr_bank, wr_stat, wr_idx;
  assign wr_ctrl = do_wr & (wa == OFS_CTRL);
  assign wr_pc = do_wr & (wa == OFS_PC);
  assign wr_wreg = do_wr & (wa == OFS_WREG);
  assign wr_bank = do_wr & (wa == OFS_BANK);
  assign wr_stat = do_wr & (wa == OFS_STATUS);
  assign wr_idx = do_wr & (wa == OFS_IDX);
  logic [31:0] m_ctrl, m_pc, m_wreg, m_bank, m_stat, m_idx;
  assign m_ctrl = merge({30'h0, ctrl_ff}, wd, ws);
  assign m_pc = merge({11'h0, pc_ff}, wd, ws);
  assign m_wreg = merge({24'h0, wreg_ff}, wd, ws);
  assign m_bank = merge({28'h0, bank_ff}, wd, ws);
  assign m_stat = merge({27'h0, status_ff}, wd, ws);
  assign m_idx = merge({20'h0, idx_ff}, wd, ws);

  // Channel handshake flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      aw_got_ff <= aw_have & ~do_wr;
      w_got_ff <= w_have & ~do_wr;
      if (aw_hs) awaddr_ff <= awaddr;
      if (w_hs) wdata_ff <= wdata;
      if (w_hs) wstrb_ff <= wstrb;
      if (do_wr) bresp_ff <= wa_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic ar_hs, nxt_rvalid;
  logic [31:0] rd_word;
  logic rd_hit;
  assign ar_hs = arvalid & arready_ff;
  assign nxt_rvalid = ar_hs | (rvalid_ff & ~rready);
  assign rd_hit = (araddr == OFS_CTRL) | (araddr == OFS_PC) | (araddr == OFS_WREG)
                | (araddr == OFS_BANK) | (araddr == OFS_STATUS) | (araddr == OFS_IDX)
                | (araddr == OFS_IR);
  assign rd_word = (araddr == OFS_CTRL) ? {30'h0, ctrl_ff} :
                   (araddr == OFS_PC) ? {11'h0, pc_ff} :
                   (araddr == OFS_WREG) ? {24'h0, wreg_ff} :
                   (araddr == OFS_BANK) ? {28'h0, bank_ff} :
                   (araddr == OFS_STATUS) ? {27'h0, status_ff} :
                   (araddr == OFS_IDX) ? {20'h0, idx_ff} :
                   (araddr == OFS_IR) ? {16'h0, ir_ff} : 32'h00000000;

  // Read data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= RESP_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (ar_hs) rdata_ff <= rd_word;
      if (ar_hs) rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  logic exec, q4_exec, jump_ok, inc_q1, inc_q4, inc_to_w, inc_to_f;
  logic [7:0] fld_f;
  logic [19:0] jmp_k;
  logic [20:0] jmp_tgt, pc_plus;
  logic [11:0] op_addr;
  logic idx_mode;
  alu_out_t alu;
  assign exec = (st_ff == ST_EXEC);
  assign q4_exec = exec & (q_ff == Q4);
  assign fld_f = ir_ff[7:0];
  assign jmp_k = {prog_rdata[11:0], klo_ff};
  assign jmp_tgt = {jmp_k, 1'b0};
  assign jump_ok = q4_exec & is_jump(ir_ff) & (prog_rdata[15:12] == JUMP_W2_OP);
  assign pc_plus = pc_ff + PC_STEP;
  assign inc_q1 = exec & (q_ff == Q1) & is_inc_file(ir_ff);
  assign inc_q4 = q4_exec & is_inc_file(ir_ff);
  assign inc_to_w = inc_q4 & ~ir_ff[9];
  assign inc_to_f = inc_q4 & ir_ff[9];

  // Operand address: window, bank pointer or indexed offset
  data_addr_gen u_addr (
    .f(fld_f),
    .a(ir_ff[8]),
    .ext_en(ctrl_ff[CTRL_EXT]),
    .bank(bank_ff),
    .idx_base(idx_ff),
    .addr(op_addr),
    .idx_mode(idx_mode)
  );

  // Increment and flags
  inc_alu u_alu (
    .opnd(opnd_ff),
    .out(alu)
  );

  // Sequencer: halt, execute, or idle second cycle of a jump
  always_comb begin
    nxt_st = st_ff;
    if (q_ff == Q4) begin
      case (st_ff)
        ST_HALT: nxt_st = ctrl_ff[CTRL_RUN] ? ST_EXEC : ST_HALT;
        ST_EXEC: nxt_st = jump_ok ? ST_NOP : (ctrl_ff[CTRL_RUN] ? ST_EXEC : ST_HALT);
        ST_NOP: nxt_st = ctrl_ff[CTRL_RUN] ? ST_EXEC : ST_HALT;
        default: nxt_st = ST_HALT;
      endcase
    end
  end

  // ----------------------------------------
  // Quarter phases, fetch and program counter
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_ff <= Q1;
      st_ff <= ST_HALT;
      pc_ff <= RST_PC;
      ir_ff <= RST_IR;
      klo_ff <= 8'h00;
    end else begin
      q_ff <= q_ff + 2'h1;
      st_ff <= nxt_st;
      if (exec & (q_ff == Q2)) klo_ff <= ir_ff[7:0];
      if (jump_ok) pc_ff <= jmp_tgt;
      else if ((q_ff == Q4) & ctrl_ff[CTRL_RUN]) pc_ff <= pc_plus;
      else if (wr_pc) pc_ff <= {m_pc[20:1], 1'b0};
      if ((q_ff == Q4) & ctrl_ff[CTRL_RUN]) ir_ff <= prog_rdata;
    end
  end

  // ----------------------------------------
  // Increment datapath: Q1 address, Q2 read, Q3 compute, Q4 write
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opnd_ff <= 8'h00;
      res_ff <= '0;
      dmem_ff <= '0;
    end else begin
      dmem_ff.we <= inc_to_f;
      if (inc_q1) dmem_ff.addr <= op_addr;
      if (exec & (q_ff == Q2)) opnd_ff <= dmem_rdata;
      if (exec & (q_ff == Q3)) res_ff <= alu;
      if (inc_to_f) dmem_ff.wdata <= res_ff.res;
    end
  end

  // ----------------------------------------
  // Software registers; core updates win
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= RST_CTRL;
      bank_ff <= RST_BANK;
      idx_ff <= RST_IDX;
      wreg_ff <= RST_WREG;
      status_ff <= RST_STATUS;
    end else begin
      if (wr_ctrl) ctrl_ff <= m_ctrl[1:0];
      if (wr_bank) bank_ff <= m_bank[3:0];
      if (wr_idx) idx_ff <= m_idx[11:0];
      if (inc_to_w) wreg_ff <= res_ff.res;
      else if (wr_wreg) wreg_ff <= m_wreg[7:0];
      if (inc_q4) status_ff <= res_ff.flags;
      else if (wr_stat) status_ff <= m_stat[4:0];
    end
  end

  // Outputs straight from flops
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign prog_addr = pc_ff;
  assign dmem = dmem_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_jump_second_word: assert property (q4_exec && is_jump(ir_ff) && ctrl_ff[CTRL_RUN]
    && prog_rdata[15:12] != JUMP_W2_OP |=> pc_ff == $past(pc_plus) && st_ff == ST_EXEC)
    else $error("jump without second-word prefix changed flow");
  a_jump_pc_load: assert property (jump_ok |=> pc_ff == $past(jmp_tgt) && !pc_ff[0])
    else $error("jump target not loaded into pc");
  a_jump_full_reach: assert property (jump_ok |=> pc_ff[20:1] == {$past(prog_rdata[11:0]), $past(ir_ff[7:0])})
    else $error("jump literal truncated");
  a_jump_idle_cycle: assert property (jump_ok |=> (st_ff == ST_NOP && !dmem_ff.we)[*4])
    else $error("second jump cycle not idle");
  a_inc_flags: assert property (inc_q4 |=> status_ff[FLG_Z] == ($past(opnd_ff) == 8'hff)
    && status_ff[FLG_OV] == ($past(opnd_ff) == 8'h7f))
    else $error("increment flags wrong");
  a_inc_to_acc: assert property (inc_to_w |=> !dmem_ff.we && wreg_ff == $past(opnd_ff) + 8'h01)
    else $error("accumulator destination wrong");
  a_bank_select: assert property (inc_q1 && ir_ff[8] |=> dmem_ff.addr[11:8] == $past(bank_ff))
    else $error("bank pointer not used");
  a_index_mode: assert property (inc_q1 && idx_mode |=> dmem_ff.addr == $past(idx_ff) + {4'h0, $past(fld_f)})
    else $error("indexed offset address wrong");
  a_inc_wrap: assert property (inc_to_f && opnd_ff == 8'hff |=> dmem_ff.we
    && dmem_ff.wdata == 8'h00 && status_ff[FLG_C])
    else $error("increment did not wrap");
  c_jump_taken: cover property (jump_ok);
  c_inc_to_file: cover property (inc_to_f);
  c_inc_indexed: cover property (inc_q1 && idx_mode);
  c_bus_error: cover property (bvalid_ff && bresp_ff == RESP_SLVERR);
endmodule

// File: design/core_pkg.sv
// Purpose: Shared constants and types for the jump / increment execution core
// Assumes: 200 MHz aclk, four clocks make one instruction cycle
// Notes: Register offsets are byte addresses on the AXI4-Lite slave
package core_pkg;
  // ----------------------------------------
  // Register map and field positions
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PC = 8'h04;
  localparam logic [7:0] OFS_WREG = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IDX = 8'h14;
  localparam logic [7:0] OFS_IR = 8'h18;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [11:0] RST_IDX = 12'h000;
  localparam logic [20:0] RST_PC = 21'h000000;
  localparam logic [15:0] RST_IR = 16'h0000;
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic [4:0] RST_STATUS = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // Instruction encodings and timing
  // ----------------------------------------
  localparam logic [7:0] JUMP_W1_OP = 8'hef;
  localparam logic [3:0] JUMP_W2_OP = 4'hf;
  localparam logic [5:0] INC_FILE_OP = 6'h0a;
  localparam logic [7:0] IDX_MAX = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  localparam logic [20:0] PC_STEP = 21'h000002;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {ST_HALT, ST_EXEC, ST_NOP} exec_st_t;
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmem_req_t;
  typedef struct packed {
    logic [7:0] res;
    logic [4:0] flags;
  } alu_out_t;
endpackage

// File: design/inc_alu.sv
// Purpose: Byte increment with status flags
// Assumes: Purely combinational
// Notes: Result wraps from ff to 00
`timescale 1ns/1ps
module inc_alu (
  input wire logic [7:0] opnd,
  output core_pkg::alu_out_t out
);
  import core_pkg::*;
  // ----------------------------------------
  // Sum and carries
  // ----------------------------------------
  logic [8:0] sum9;
  logic [4:0] lo5;
  assign sum9 = {1'b0, opnd} + 9'h001;
  assign lo5 = {1'b0, opnd[3:0]} + 5'h01;
  // Result and flags
  assign out.res = sum9[7:0];
  assign out.flags[FLG_C] = sum9[8];
  assign out.flags[FLG_DC] = lo5[4];
  assign out.flags[FLG_Z] = (sum9[7:0] == 8'h00);
  assign out.flags[FLG_OV] = (opnd == 8'h7f);
  assign out.flags[FLG_N] = sum9[7];
endmodule

// File: design/data_addr_gen.sv
// Purpose: Data memory address for a byte-oriented operand
// Assumes: 12-bit data space, 16 banks of 256 bytes
// Notes: Direct window splits at 60h between bank 0 and the top bank
`timescale 1ns/1ps
module data_addr_gen (
  input wire logic [7:0] f,
  input wire logic a,
  input wire logic ext_en,
  input wire logic [3:0] bank,
  input wire logic [11:0] idx_base,
  output logic [11:0] addr,
  output logic idx_mode
);
  import core_pkg::*;
  // ----------------------------------------
  // Mode and address select
  // ----------------------------------------
  logic [11:0] win_addr;
  logic [11:0] idx_addr;
  assign idx_mode = ~a & ext_en & (f <= IDX_MAX);
  assign win_addr = (f < ACC_SPLIT) ? {4'h0, f} : {ACC_HI_BANK, f};
  assign idx_addr = idx_base + {4'h0, f};
  assign addr = idx_mode ? idx_addr : (a ? {bank, f} : win_addr);
endmodule

// File: dv/mem_model.sv
// Purpose: Program memory and banked data file facing the execution core
// Assumes: Both memories answer within the same clock, no wait states
// Notes: Unloaded program words read as 0000, which the core runs as nothing
`timescale 1ns/1ps
module mem_model (
  input wire logic aclk,
  input wire logic [20:0] prog_addr,
  output logic [15:0] prog_rdata,
  input core_pkg::dmem_req_t dmem,
  output logic [7:0] dmem_rdata
);
  import core_pkg::*;
  logic [15:0] prog [int];
  logic [7:0] data [0:4095];
  int loads;
  // ----------------------------------------
  // Loading and reading
  // ----------------------------------------
  // Bench stores words here only while the core is halted
  task automatic put(input logic [20:0] a, input logic [15:0] w);
    prog[int'(a[20:1])] = w;
    loads++;
  endtask
  // Word read, refreshed on a new address or a new load
  always @(prog_addr or loads) begin
    prog_rdata = prog.exists(int'(prog_addr[20:1])) ? prog[int'(prog_addr[20:1])] : 16'h0000;
  end
  assign dmem_rdata = data[dmem.addr];
  // Byte write on the one-clock strobe
  always @(posedge aclk) begin
    if (dmem.we) begin
      data[dmem.addr] <= dmem.wdata;
    end
  end
endmodule

// File: dv/long_jump_and_increment_exec_tb.sv
// Purpose: Self-checking bench for the long jump and byte increment core
// Assumes: Programs and data are loaded while the core is halted
// Notes: Each program ends in a self-loop so halting leaves no side effect
`timescale 1ns/1ps
module long_jump_and_increment_exec_tb;
  import core_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata, last_data;
  logic [20:0] prog_addr;
  logic [15:0] prog_rdata;
  dmem_req_t dmem;
  logic [7:0] dmem_rdata;
  int miscompares, checks_done;

  jump_incr_core u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .dmem(dmem), .dmem_rdata(dmem_rdata));
  mem_model u_mem (.aclk(aclk), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .dmem(dmem),
    .dmem_rdata(dmem_rdata));

  // Clock at 200 MHz
  always #2.5 aclk = ~aclk;
  // ----------------------------------------
  // Reporting and comparison
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic time_out();
    miscompares++;
    $display("MISMATCH at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_mem(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  // ----------------------------------------
  // Bus master and helpers
  // ----------------------------------------
  // Write: both channels offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        last_resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    time_out();
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (40) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        last_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    time_out();
  endtask
  // Flags after adding one: N, OV, Z, DC, C from high bit down
  function automatic logic [31:0] flags_of(input logic [7:0] v);
    logic [8:0] s;
    s = {1'b0, v} + 9'h001;
    return 32'({s[7], v == 8'h7f, s[7:0] == 8'h00, v[3:0] == 4'hf, s[8]});
  endfunction
  task automatic put_jump(input logic [20:0] at, input logic [19:0] k);
    u_mem.put(at, {JUMP_W1_OP, k[7:0]});
    u_mem.put(at + 21'h2, {JUMP_W2_OP, k[19:8]});
  endtask
  // Counts edges until the fetch address shows the target
  task automatic wait_pc(input logic [20:0] t, output int n);
    n = 0;
    while (prog_addr !== t) begin
      @(posedge aclk);
      n++;
      if (n > 400) time_out();
    end
  endtask
  task automatic run_prog(input logic [20:0] start, input logic ext, input logic [20:0] stop);
    int n;
    axi_wr(OFS_PC, 32'(start));
    axi_wr(OFS_CTRL, {30'h0, ext, 1'b1});
    wait_pc(stop, n);
    repeat (12) @(posedge aclk);
    axi_wr(OFS_CTRL, {30'h0, ext, 1'b0});
  endtask
  // One increment at 100h followed by a self-loop at 102h
  task automatic do_inc(input logic ext, input logic d, input logic a, input logic [7:0] f,
                        input logic [11:0] addr, input logic [7:0] init);
    u_mem.data[addr] = init;
    u_mem.put(21'h100, {INC_FILE_OP, d, a, f});
    put_jump(21'h102, 20'h00081);
    run_prog(21'h100, ext, 21'h104);
    if (d) begin
      chk_mem(u_mem.data[addr], init + 8'h01);
    end else begin
      axi_rd(OFS_WREG);
      chk_reg(last_data, {24'h0, init + 8'h01});
      chk_mem(u_mem.data[addr], init);
    end
    axi_rd(OFS_STATUS);
    chk_reg(last_data, flags_of(init));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_regs();
    logic [7:0] ofs [7] = '{OFS_CTRL, OFS_PC, OFS_WREG, OFS_BANK, OFS_STATUS, OFS_IDX, OFS_IR};
    for (int i = 0; i < 7; i++) begin
      axi_rd(ofs[i]);
      chk_reg(last_data, 32'h0);
    end
    axi_rd(8'h1c);
    chk_reg({last_data[29:0], last_resp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h1c, 32'h5a5a5a5a);
    chk_reg(32'(last_resp), 32'(RESP_SLVERR));
    axi_wr(OFS_IR, 32'h00001234);
    axi_rd(OFS_IR);
    chk_reg(last_data, 32'h0);
    chk_reg(32'(last_resp), 32'(RESP_OKAY));
    axi_wr(OFS_BANK, 32'hfffffff2);
    axi_rd(OFS_BANK);
    chk_reg(last_data, 32'h2);
  endtask
  task automatic sc_inc_banked();
    do_inc(1'b0, 1'b1, 1'b1, 8'h10, 12'h210, 8'hff);
  endtask
  task automatic sc_inc_acc();
    do_inc(1'b0, 1'b0, 1'b0, 8'h80, 12'hf80, 8'h7f);
    do_inc(1'b0, 1'b1, 1'b0, 8'h05, 12'h005, 8'h0f);
  endtask
  task automatic sc_inc_idx();
    axi_wr(OFS_IDX, 32'h00000300);
    do_inc(1'b1, 1'b1, 1'b0, 8'h05, 12'h305, 8'h0e);
    do_inc(1'b1, 1'b0, 1'b0, 8'h5f, 12'h35f, 8'h80);
    do_inc(1'b1, 1'b1, 1'b0, 8'h60, 12'hf60, 8'h20);
    do_inc(1'b1, 1'b1, 1'b1, 8'h05, 12'h205, 8'h01);
  endtask
  // Jump from 0 to 1579bch; the word after the pair must never run
  task automatic sc_jump();
    int n;
    u_mem.data[12'h020] = 8'h33;
    u_mem.data[12'h021] = 8'h40;
    put_jump(21'h0, 20'habcde);
    u_mem.put(21'h4, {INC_FILE_OP, 2'b10, 8'h20});
    u_mem.put(21'h1579bc, {INC_FILE_OP, 2'b10, 8'h21});
    put_jump(21'h1579be, 20'habcdf);
    axi_wr(OFS_PC, 32'h0);
    axi_wr(OFS_CTRL, 32'h1);
    wait_pc(21'h2, n);
    wait_pc(21'h1579bc, n);
    chk_reg(32'(prog_addr), 32'h1579bc);
    chk_reg(32'(n), 32'd4);
    wait_pc(21'h1579be, n);
    chk_reg(32'(n), 32'd4);
    repeat (24) @(posedge aclk);
    axi_wr(OFS_CTRL, 32'h0);
    chk_mem(u_mem.data[12'h020], 8'h33);
    chk_mem(u_mem.data[12'h021], 8'h41);
  endtask
  // Largest literal reaches 1ffffeh; the core then wraps into the jump above
  task automatic sc_jump_max();
    u_mem.data[12'h022] = 8'h05;
    put_jump(21'h200, 20'hfffff);
    u_mem.put(21'h1ffffe, {INC_FILE_OP, 2'b10, 8'h22});
    run_prog(21'h200, 1'b0, 21'h1579c0);
    chk_mem(u_mem.data[12'h022], 8'h06);
  endtask
  // Jump whose second word lacks the prefix: no branch, that word runs as an increment
  task automatic sc_jump_bad();
    u_mem.data[12'h023] = 8'h10;
    u_mem.put(21'h300, {JUMP_W1_OP, 8'h40});
    u_mem.put(21'h302, {INC_FILE_OP, 2'b10, 8'h23});
    put_jump(21'h304, 20'h00182);
    run_prog(21'h300, 1'b0, 21'h306);
    chk_mem(u_mem.data[12'h023], 8'h11);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    sc_regs();
    sc_inc_banked();
    sc_inc_acc();
    sc_inc_idx();
    sc_jump();
    sc_jump_max();
    sc_jump_bad();
    give_verdict();
  end
endmodule
